/* File: shared/ise_pkg.sv */
// Constants and types for the I2C script engine
package ise_pkg;
  localparam int CLK_KHZ = 25000;
  localparam int MS_CYCLES = CLK_KHZ;
  localparam int ACK_TMO_DEFAULT = 0;
  localparam logic [1:0] DIR_READ = 2'h1;
  localparam logic DIR_BIT_READ = 1'h1;
  localparam logic DIR_BIT_WRITE = 1'h0;
  localparam logic [3:0] OP_ADDR_READ = 4'h1;
  localparam logic [3:0] OP_ADDR_WRITE = 4'h2;
  localparam logic [3:0] OP_SCL_RATE = 4'h3;
  localparam logic [3:0] OP_MS_WAIT = 4'h4;
  localparam logic [3:0] OP_LINE_DIR = 4'h5;
  localparam logic [3:0] OP_ACK_TMO = 4'h6;
  localparam logic [3:0] OP_START = 4'h7;
  localparam logic [3:0] OP_END = 4'h8;
  localparam int NUM_RATES = 4;
  localparam logic [15:0] RATE_0 = 16'h0020;
  localparam logic [15:0] RATE_1 = 16'h0064;
  localparam logic [15:0] RATE_2 = 16'h00fa;
  localparam logic [15:0] RATE_3 = 16'h0190;
  localparam logic line_dir_in = 1'h0;
  localparam logic line_dir_out = 1'h1;
  typedef enum {
    ST_IDLE, ST_FETCH, ST_EXEC, ST_ADDR, ST_ACKWAIT, ST_WAIT, ST_DONE
  } ise_state_type;
endpackage : ise_pkg

/* File: rtl/ise_bit_shifter.sv */
// I2C address byte shifter with acknowledge sampling
`timescale 1ns/1ns
module ise_bit_shifter import ise_pkg::*; #(
  parameter int DIV_W = 12
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic go,
  input wire logic [7:0] data,
  input wire logic [DIV_W-1:0] half_period,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_oe,
  output logic done,
  output logic acked
);
  logic [DIV_W-1:0] cnt;
  logic [3:0] bit_idx;
  logic [7:0] shreg;
  logic busy;
  logic phase_end;
  logic last_bit;
  assign phase_end = cnt == '0;
  assign last_bit = bit_idx == 4'h8;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      busy <= 1'b0;
      cnt <= '0;
      bit_idx <= 4'h0;
      shreg <= 8'h00;
      scl_out <= 1'b0;
      sda_oe <= 1'b0;
      done <= 1'b0;
      acked <= 1'b0;
    end else begin
      done <= 1'b0;
      if (go && !busy) begin
        busy <= 1'b1;
        shreg <= data;
        bit_idx <= 4'h0;
        cnt <= half_period;
        scl_out <= 1'b0;
        sda_oe <= !data[7];
      end else if (busy) begin
        if (!phase_end) begin
          cnt <= cnt - 1'b1;
        end else if (!scl_out) begin
          cnt <= half_period;
          scl_out <= 1'b1;
          if (last_bit) begin
            acked <= !sda_in; // Slave acknowledge slot
          end
        end else begin
          cnt <= half_period;
          scl_out <= 1'b0;
          if (last_bit) begin
            busy <= 1'b0;
            done <= 1'b1;
            sda_oe <= 1'b0;
          end else begin
            bit_idx <= bit_idx + 4'h1;
            shreg <= {shreg[6:0], 1'b0};
            // Release SDA for the ack slot after eight bits
            sda_oe <= (bit_idx == 4'h7) ? 1'b0 : !shreg[6];
          end
        end
      end
    end
  end
endmodule : ise_bit_shifter

/* File: rtl/ise_engine.sv */
// I2C script engine: runs commands one after another
// Contract
// - Address-with-read sends the 7-bit address with direction bit 1.
// - Address-with-write sends the 7-bit address with direction bit 0.
// - Address shifts 7 bits then direction, then samples the slave ack.
// - A not-acknowledged address enters ack polling under the timeout.
// - Zero timeout disables polling; nonzero retries until ack or expiry.
// - Polling happens only for an address right after start or restart.
// - The timeout holds for the script and resets when the script ends.
// - All bus activity goes to the port chosen at launch.
// - Rate command carries kHz; only supported rates are generated.
// - An unsupported rate falls to the nearest lower one with a warning.
// - A rate below all supported ones is rejected with an error.
// - Wait command waits whole ms from an 8-bit count after prior command.
// - Line-configure sets a line input at 0 and output at 1.
// - Port chosen by port index and line by line index; single port is 0.
`timescale 1ns/1ns
module ise_engine import ise_pkg::*; #(
  parameter int MS_COUNT = MS_CYCLES,
  parameter int PORTS = 2,
  parameter int IO_PORTS = 1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic script_launch,
  input wire logic [0:0] launch_port,
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_op,
  input wire logic [15:0] cmd_arg,
  input wire logic [7:0] io_port_index,
  input wire logic [7:0] io_line_index,
  input wire logic line_dir_value,
  input wire logic [PORTS-1:0] sda_in,
  output logic cmd_ready,
  output logic [PORTS-1:0] scl_out,
  output logic [PORTS-1:0] sda_oe,
  output logic [7:0] line_dir,
  output logic busy,
  output logic rate_warn,
  output logic rate_err,
  output logic nack_err
);
  ise_state_type state;
  logic [0:0] port;
  logic [3:0] op;
  logic [15:0] arg;
  logic [15:0] ack_tmo;
  logic [15:0] ms_left;
  logic [24:0] tick;
  logic after_start;
  logic polling;
  logic [11:0] half_period;
  logic sh_go;
  logic sh_scl;
  logic sh_oe;
  logic sh_done;
  logic sh_acked;
  logic [7:0] addr_byte;
  logic [11:0] next_half;
  logic rate_ok;
  logic rate_exact;
  logic ms_tick;
  logic port_sda;

  // Direction bit forced from the opcode, host bit ignored
  assign addr_byte = {arg[6:0],
    (op == OP_ADDR_READ) ? DIR_BIT_READ : DIR_BIT_WRITE};
  // Round down to supported rate; half period in clk cycles
  assign rate_ok = arg >= RATE_0;
  assign rate_exact = arg == RATE_0 || arg == RATE_1 || arg == RATE_2
    || arg == RATE_3;
  assign next_half = (arg >= RATE_3) ? 12'(CLK_KHZ / (2 * RATE_3)) :
    (arg >= RATE_2) ? 12'(CLK_KHZ / (2 * RATE_2)) :
    (arg >= RATE_1) ? 12'(CLK_KHZ / (2 * RATE_1)) :
    12'(CLK_KHZ / (2 * RATE_0));
  assign ms_tick = tick == 25'(MS_COUNT - 1);
  assign port_sda = sda_in[port];
  assign sh_go = state == ST_ADDR;

  ise_bit_shifter #(.DIV_W(12)) u_shift (
    .clk(clk),
    .resetn(resetn),
    .go(sh_go),
    .data(addr_byte),
    .half_period(half_period),
    .sda_in(port_sda),
    .scl_out(sh_scl),
    .sda_oe(sh_oe),
    .done(sh_done),
    .acked(sh_acked)
  );

  always_ff @(posedge clk) begin
    if (!resetn) begin
      scl_out <= '0;
      sda_oe <= '0;
    end else begin
      // Only the launched port sees bus activity
      for (int i = 0; i < PORTS; i++) begin
        scl_out[i] <= (i == int'(port)) ? sh_scl : 1'b0;
        sda_oe[i] <= (i == int'(port)) ? sh_oe : 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn || state != ST_WAIT && !polling || ms_tick) begin
      tick <= '0;
    end else begin
      tick <= tick + 25'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= ST_IDLE;
      port <= 1'h0;
      op <= 4'h0;
      arg <= 16'h0000;
      ack_tmo <= 16'(ACK_TMO_DEFAULT);
      ms_left <= 16'h0000;
      after_start <= 1'b0;
      polling <= 1'b0;
      half_period <= 12'(CLK_KHZ / (2 * RATE_1));
      line_dir <= 8'h00;
      busy <= 1'b0;
      cmd_ready <= 1'b0;
      rate_warn <= 1'b0;
      rate_err <= 1'b0;
      nack_err <= 1'b0;
    end else begin
      cmd_ready <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (script_launch) begin
            port <= launch_port;
            busy <= 1'b1;
            rate_warn <= 1'b0;
            rate_err <= 1'b0;
            nack_err <= 1'b0;
            cmd_ready <= 1'b1;
            state <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          cmd_ready <= !cmd_valid;
          if (cmd_valid) begin // One command at a time
            op <= cmd_op;
            arg <= cmd_arg;
            state <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          state <= ST_FETCH;
          // No ready pulse when the script ends here
          cmd_ready <= op != OP_END && (op != OP_SCL_RATE || rate_ok);
          after_start <= 1'b0;
          case (op)
            OP_START: after_start <= 1'b1; // Start issued elsewhere
            OP_ADDR_READ, OP_ADDR_WRITE: begin
              polling <= after_start && ack_tmo != 16'h0000;
              ms_left <= ack_tmo;
              cmd_ready <= 1'b0;
              state <= ST_ADDR;
            end
            OP_SCL_RATE: begin
              if (!rate_ok) begin
                rate_err <= 1'b1;
                state <= ST_DONE;
              end else begin
                half_period <= next_half;
                rate_warn <= rate_warn | !rate_exact;
              end
            end
            OP_MS_WAIT: begin
              ms_left <= {8'h00, arg[7:0]};
              cmd_ready <= 1'b0;
              state <= ST_WAIT;
            end
            OP_LINE_DIR: begin
              if (int'(io_port_index) < IO_PORTS && io_line_index < 8'h08) begin
                line_dir[io_line_index[2:0]] <= line_dir_value;
              end
            end
            OP_ACK_TMO: ack_tmo <= arg;
            OP_END: state <= ST_DONE;
            default: ;
          endcase
        end
        ST_ADDR: state <= ST_ACKWAIT; // Shifter takes go here
        ST_ACKWAIT: begin
          if (polling && ms_tick && ms_left != 16'h0000) begin
            ms_left <= ms_left - 16'h1;
          end
          if (sh_done) begin
            if (sh_acked) begin
              polling <= 1'b0;
              cmd_ready <= 1'b1;
              state <= ST_FETCH;
            end else if (polling && ms_left != 16'h0000) begin
              state <= ST_ADDR; // Retry the address
            end else begin
              polling <= 1'b0;
              nack_err <= 1'b1;
              state <= ST_DONE;
            end
          end
        end
        ST_WAIT: begin
          if (ms_left == 16'h0000) begin
            cmd_ready <= 1'b1;
            state <= ST_FETCH;
          end else if (ms_tick) begin
            ms_left <= ms_left - 16'h1;
          end
        end
        ST_DONE: begin
          ack_tmo <= 16'(ACK_TMO_DEFAULT);
          busy <= 1'b0;
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  property p_dir_read;
    @(posedge clk) disable iff (!resetn)
      (state == ST_ADDR && op == OP_ADDR_READ) |-> addr_byte[0];
  endproperty
  a_dir_read: assert property (p_dir_read) else $error("read dir not 1");
  property p_dir_write;
    @(posedge clk) disable iff (!resetn)
      (state == ST_ADDR && op == OP_ADDR_WRITE) |-> !addr_byte[0];
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("write dir not 0");
  property p_nack_abort;
    @(posedge clk) disable iff (!resetn)
      (state == ST_ACKWAIT && sh_done && !sh_acked && !polling)
        |=> nack_err && state == ST_DONE;
  endproperty
  a_nack_abort: assert property (p_nack_abort) else $error("no nack abort");
  property p_tmo_reset;
    @(posedge clk) disable iff (!resetn)
      state == ST_DONE |=> ack_tmo == 16'(ACK_TMO_DEFAULT) && !busy;
  endproperty
  a_tmo_reset: assert property (p_tmo_reset) else $error("tmo not reset");
  property p_rate_err;
    @(posedge clk) disable iff (!resetn)
      (state == ST_EXEC && op == OP_SCL_RATE && !rate_ok) |=> rate_err;
  endproperty
  a_rate_err: assert property (p_rate_err) else $error("low rate accepted");
  property p_rate_warn;
    @(posedge clk) disable iff (!resetn)
      (state == ST_EXEC && op == OP_SCL_RATE && rate_ok && !rate_exact)
        |=> rate_warn;
  endproperty
  a_rate_warn: assert property (p_rate_warn) else $error("no rate warning");
  property p_poll_gate;
    @(posedge clk) disable iff (!resetn)
      (state == ST_EXEC && (op == OP_ADDR_READ || op == OP_ADDR_WRITE)
        && !after_start) |=> !polling;
  endproperty
  a_poll_gate: assert property (p_poll_gate) else $error("poll w/o start");
  property p_other_port_quiet;
    @(posedge clk) disable iff (!resetn)
      busy |=> (sda_oe & ~(PORTS'(1) << port)) == '0;
  endproperty
  a_other_port_quiet: assert property (p_other_port_quiet) else $error("wrong port");
  property p_ready_fetch;
    @(posedge clk) disable iff (!resetn)
      cmd_ready |-> state == ST_FETCH;
  endproperty
  a_ready_fetch: assert property (p_ready_fetch) else $error("stray ready");
  sequence s_nack_retry;
    state == ST_ACKWAIT && sh_done && !sh_acked && polling && ms_left != '0;
  endsequence
  sequence s_resend;
    state == ST_ADDR ##1 state == ST_ACKWAIT;
  endsequence
  property p_poll_retry;
    @(posedge clk) disable iff (!resetn) s_nack_retry |=> s_resend;
  endproperty
  a_poll_retry: assert property (p_poll_retry) else $error("no retry");
endmodule : ise_engine

/* File: test/ise_slave.sv */
// Behavioural I2C slave that shifts in one address byte and answers the ack
`timescale 1ns/1ns
module ise_slave (
  input wire logic clk,
  input wire logic clr,
  input wire logic ack_en,
  input wire logic scl,
  input wire logic sda,
  output logic pull,
  output logic [7:0] rx,
  output logic [3:0] nbits
);
  logic scl_q;
  always_ff @(posedge clk) begin
    scl_q <= scl;
    if (clr) begin
      nbits <= 4'h0;
      pull <= 1'h0;
    end else if (scl && !scl_q) begin
      if (nbits < 4'h8) begin
        rx <= {rx[6:0], sda};
      end
      nbits <= nbits + 4'h1;
    end else if (!scl && scl_q) begin
      // Ack slot held from the 8th falling edge to the 9th
      pull <= ack_en && (nbits == 4'h8);
      // Restart the count so that polling retries are shifted in afresh
      if (nbits == 4'h9) begin
        nbits <= 4'h0;
      end
    end
  end
endmodule : ise_slave

/* File: test/tb.sv */
// Self-checking testbench for the I2C script engine
`timescale 1ns/1ns
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb;
  import ise_pkg::*;
  logic clk, resetn, script_launch, cmd_valid, line_dir_value;
  logic cmd_ready, busy, rate_warn, rate_err, nack_err, p0, p1;
  logic [0:0] launch_port;
  logic [3:0] cmd_op, nb0, nb1;
  logic [15:0] cmd_arg;
  logic [7:0] io_port_index, io_line_index, line_dir, rx0, rx1;
  logic [1:0] sda_in, scl_out, sda_oe, clr, ack_en;
  logic [15:0] rt [8] = '{16'h0020, 16'h0064, 16'h00fa, 16'h0190,
    16'h0096, 16'h01f4, 16'h001f, 16'h0000};
  int fails, num_checks, n, per;
  // Open-drain SDA with pull-up: low if either party pulls
  assign sda_in = ~(sda_oe | {p1, p0});
  ise_engine #(.MS_COUNT(10)) i_dut (.clk(clk), .resetn(resetn),
    .script_launch(script_launch), .launch_port(launch_port),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_arg(cmd_arg),
    .io_port_index(io_port_index), .io_line_index(io_line_index),
    .line_dir_value(line_dir_value), .sda_in(sda_in),
    .cmd_ready(cmd_ready), .scl_out(scl_out), .sda_oe(sda_oe),
    .line_dir(line_dir), .busy(busy), .rate_warn(rate_warn),
    .rate_err(rate_err), .nack_err(nack_err));
  ise_slave i_s0 (.clk(clk), .clr(clr[0]), .ack_en(ack_en[0]),
    .scl(scl_out[0]), .sda(sda_in[0]), .pull(p0), .rx(rx0), .nbits(nb0));
  ise_slave i_s1 (.clk(clk), .clr(clr[1]), .ack_en(ack_en[1]),
    .scl(scl_out[1]), .sda(sda_in[1]), .pull(p1), .rx(rx1), .nbits(nb1));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run
  task automatic timeout_hit(input string what);
    fails++;
    $display("MISMATCH %s exp done got timeout", what);
    complete_run();
  endtask : timeout_hit
  // Cycles between two rises of port 0 SCL
  task automatic scl_period(output int per_cnt);
    int k;
    k = 0;
    per_cnt = 0;
    while (scl_out[0] !== 1'h1 && k < 2000) begin
      @(negedge clk);
      k++;
    end
    while (scl_out[0] !== 1'h0 && per_cnt < 2000) begin
      @(negedge clk);
      per_cnt++;
    end
    while (scl_out[0] !== 1'h1 && per_cnt < 2000) begin
      @(negedge clk);
      per_cnt++;
    end
    if (k == 2000 || per_cnt == 2000) timeout_hit("scl period");
  endtask : scl_period
  // Period close to the ideal one for a rate in kHz
  function automatic logic per_near(input int p, input int khz);
    return p >= CLK_KHZ / khz - 4 && p <= CLK_KHZ / khz + 4;
  endfunction : per_near
  task automatic launch(input logic [0:0] p);
    clr = 2'h3;
    launch_port = p;
    script_launch = 1'h1;
    @(negedge clk);
    script_launch = 1'h0;
    clr = 2'h0;
  endtask : launch
  // Fields stay put one cycle past the taking edge, since EXEC samples them
  task automatic send(input logic [3:0] op, input logic [15:0] arg);
    n = 0;
    while (cmd_ready !== 1'h1 && n < 30000) begin
      @(negedge clk);
      n++;
    end
    if (n == 30000) timeout_hit("cmd_ready");
    cmd_op = op;
    cmd_arg = arg;
    cmd_valid = 1'h1;
    @(negedge clk);
    cmd_valid = 1'h0;
    @(negedge clk);
  endtask : send
  task automatic wait_idle(input int lim);
    n = 0;
    while (busy !== 1'h0 && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (n == lim) timeout_hit("busy");
  endtask : wait_idle
  task automatic wait_frame();
    n = 0;
    while (nb0 !== 4'h9 && n < 30000) begin
      @(negedge clk);
      n++;
    end
    if (n == 30000) timeout_hit("frame");
  endtask : wait_frame
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  initial begin
    {resetn, script_launch, cmd_valid, line_dir_value, launch_port} = '0;
    {cmd_op, cmd_arg, io_port_index, io_line_index, clr} = '0;
    ack_en = 2'h3;
    fails = 0;
    num_checks = 0;
    repeat (20) @(negedge clk);
    `CHK("busy after reset", 1'h0, busy)
    `CHK("line_dir after reset", 8'h00, line_dir)
    resetn = 1'h1;
    launch(1'h0);
    send(OP_START, 16'h0000);
    send(OP_ADDR_WRITE, 16'h005a);
    send(OP_END, 16'h0000);
    wait_idle(30000);
    `CHK("write address byte", 8'hb4, rx0)
    `CHK("idle port bits", 4'h0, nb1)
    `CHK("ack seen", 1'h0, nack_err)
    $display("test address write done");
    launch(1'h1);
    send(OP_START, 16'h0000);
    send(OP_ADDR_READ, 16'h00b3);
    send(OP_END, 16'h0000);
    wait_idle(30000);
    `CHK("read address byte", 8'h67, rx1)
    `CHK("idle port bits", 4'h0, nb0)
    $display("test address read done");
    ack_en = 2'h0;
    launch(1'h0);
    send(OP_START, 16'h0000);
    send(OP_ADDR_WRITE, 16'h0011);
    wait_idle(4000);
    `CHK("nack no polling", 1'h1, nack_err)
    launch(1'h0);
    send(OP_ACK_TMO, 16'h0400);
    send(OP_START, 16'h0000);
    send(OP_ADDR_WRITE, 16'h0011);
    wait_frame();
    ack_en = 2'h3;
    send(OP_END, 16'h0000);
    wait_idle(30000);
    `CHK("polling got ack", 1'h0, nack_err)
    launch(1'h0);
    send(OP_ACK_TMO, 16'h0400);
    send(OP_START, 16'h0000);
    send(OP_ADDR_WRITE, 16'h0011);
    wait_frame();
    ack_en = 2'h0;
    send(OP_ADDR_WRITE, 16'h0022);
    wait_idle(4000);
    `CHK("no polling without start", 1'h1, nack_err)
    // A leftover timeout would poll far past this bound
    launch(1'h0);
    send(OP_START, 16'h0000);
    send(OP_ADDR_WRITE, 16'h0022);
    wait_idle(4000);
    `CHK("timeout back to default", 1'h1, nack_err)
    // Timeout spans just over one frame: one retry, then expiry
    launch(1'h0);
    send(OP_ACK_TMO, 16'h00f0);
    send(OP_START, 16'h0000);
    send(OP_ADDR_WRITE, 16'h0022);
    wait_idle(8000);
    `CHK("poll retried", 1'h1, (n > 3000))
    `CHK("poll expired", 1'h1, nack_err)
    $display("test ack polling done");
    ack_en = 2'h3;
    for (int i = 0; i < 8; i++) begin
      launch(1'h0);
      send(OP_SCL_RATE, rt[i]);
      if (i < 6) send(OP_END, 16'h0000);
      wait_idle(100);
      `CHK("rate warn", (i == 4 || i == 5), rate_warn)
      `CHK("rate err", (i >= 6), rate_err)
    end
    launch(1'h0);
    send(OP_SCL_RATE, 16'h0096);
    send(OP_START, 16'h0000);
    send(OP_ADDR_WRITE, 16'h005a);
    scl_period(per);
    `CHK("scl period 150", 1'h1, per_near(per, RATE_1))
    send(OP_SCL_RATE, 16'h01f4);
    send(OP_START, 16'h0000);
    send(OP_ADDR_WRITE, 16'h005a);
    scl_period(per);
    `CHK("scl period 500", 1'h1, per_near(per, RATE_3))
    send(OP_END, 16'h0000);
    wait_idle(30000);
    $display("test scl rate done");
    launch(1'h0);
    send(OP_MS_WAIT, 16'h0003);
    n = 0;
    while (cmd_ready !== 1'h1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (n == 200) timeout_hit("ms wait");
    `CHK("wait length", 1'h1, (n >= 28 && n <= 34))
    send(OP_END, 16'h0000);
    wait_idle(100);
    $display("test ms wait done");
    launch(1'h0);
    io_line_index = 8'h05;
    line_dir_value = line_dir_out;
    send(OP_LINE_DIR, 16'h0000);
    io_line_index = 8'h00;
    send(OP_LINE_DIR, 16'h0000);
    io_line_index = 8'h05;
    line_dir_value = line_dir_in;
    send(OP_LINE_DIR, 16'h0000);
    // A port that does not exist leaves the lines alone
    io_port_index = 8'h01;
    io_line_index = 8'h03;
    line_dir_value = line_dir_out;
    send(OP_LINE_DIR, 16'h0000);
    io_port_index = 8'h00;
    send(OP_END, 16'h0000);
    wait_idle(100);
    `CHK("line directions", 8'h01, line_dir)
    $display("test line dir done");
    complete_run();
  end
endmodule : tb
